// [verilog/gpt_pkg.sv]
// shared types and constants of the general purpose timer block
package gpt_pkg;

    // ****************************************
    // event bit positions in the status word
    // ****************************************
    localparam int GPT_EV_W = 6;
    localparam int GPT_EV_TO_LO = 0;
    localparam int GPT_EV_CAP_LO = 1;
    localparam int GPT_EV_TO_HI = 2;
    localparam int GPT_EV_CAP_HI = 3;
    localparam int GPT_EV_TO_32 = 4;
    localparam int GPT_EV_RTC = 5;

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [15:0] GPT_CNT16_RST = 16'hffff;
    localparam logic [31:0] GPT_CNT32_RST = 32'hffff_ffff;
    localparam logic [7:0] GPT_PRE_RST = 8'h00;
    localparam logic [5:0] GPT_STAT_RST = 6'h00;
    localparam logic [1:0] GPT_PIN_OE_N_RST = 2'h3;

    // ****************************************
    // modes
    // ****************************************
    typedef enum logic [2:0] {
        GPT_ONE_SHOT,
        GPT_PERIODIC,
        GPT_EVT_COUNT,
        GPT_EDGE_TIME,
        GPT_PWM
    } gpt_mode_t;

    typedef enum logic [1:0] {
        GPT_J_ONE_SHOT,
        GPT_J_PERIODIC,
        GPT_J_RTC
    } gpt_join_t;

    typedef enum logic [1:0] {
        GPT_EDGE_RISE,
        GPT_EDGE_FALL,
        GPT_EDGE_BOTH
    } gpt_edge_t;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic en;
        gpt_mode_t mode;
        gpt_edge_t edge_sel;
        logic pwm_inv;
        logic adc_en;
        logic [7:0] prescale;
        logic [15:0] load;
        logic [15:0] match;
    } gpt_half_cfg_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] capture;
    } gpt_half_stat_t;

endpackage

// [verilog/gpt_half.sv]
// one 16-bit timer half: prescaled counter, edge counter, capture and pwm
`timescale 1ns/100ps
module gpt_half (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire gpt_pkg::gpt_half_cfg_t cfg,
    input wire logic pin_lvl,
    // results
    output logic [15:0] count_q,
    output logic [15:0] capture_q,
    output logic timeout_q,
    output logic capture_ev_q,
    output logic pwm_q
);

    logic [7:0] pre_q;
    logic pin_prev_q;
    logic done_q;
    logic tick;
    logic edge_hit;
    logic cap_hit;
    logic zero;
    logic is_to;

    function automatic logic edge_match(input gpt_pkg::gpt_edge_t sel, input logic cur,
                                        input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        case (sel)
            gpt_pkg::GPT_EDGE_RISE: edge_match = rise;
            gpt_pkg::GPT_EDGE_FALL: edge_match = fall;
            default: edge_match = rise | fall;
        endcase
    endfunction

    assign tick = run && (pre_q == 8'h00);
    assign edge_hit = run && edge_match(cfg.edge_sel, pin_lvl, pin_prev_q);
    assign cap_hit = edge_hit && (cfg.mode == gpt_pkg::GPT_EDGE_TIME);
    assign zero = (count_q == 16'h0000);

    always_comb begin
        case (cfg.mode)
            gpt_pkg::GPT_ONE_SHOT: is_to = tick && zero && !done_q;
            gpt_pkg::GPT_EVT_COUNT: is_to = edge_hit && (count_q == cfg.match);
            default: is_to = tick && zero;
        endcase
    end

    // ****************************************
    // prescaler and edge history
    // ****************************************
    // divide by prescale plus one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q <= gpt_pkg::GPT_PRE_RST;
        end else if (!run || pre_q == 8'h00) begin
            pre_q <= cfg.prescale;
        end else begin
            pre_q <= pre_q - 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_lvl;
        end
    end

    // ****************************************
    // counter
    // ****************************************
    // timer or event counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= gpt_pkg::GPT_CNT16_RST;
        end else if (!run) begin
            count_q <= cfg.load;
        end else if (cfg.mode == gpt_pkg::GPT_EVT_COUNT) begin
            if (edge_hit) begin
                count_q <= (count_q == cfg.match) ? cfg.load : count_q - 16'h0001;
            end
        end else if (tick && !zero) begin
            count_q <= count_q - 16'h0001;
        end else if (tick && cfg.mode != gpt_pkg::GPT_ONE_SHOT) begin
            count_q <= cfg.load;
        end
    end

    // one-shot parks at zero and fires once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (!run) begin
            done_q <= 1'b0;
        end else if (is_to && cfg.mode == gpt_pkg::GPT_ONE_SHOT) begin
            done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timeout_q <= 1'b0;
        end else begin
            timeout_q <= is_to;
        end
    end

    // ****************************************
    // capture and pwm
    // ****************************************
    // edge capture of count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_q <= 16'h0000;
            capture_ev_q <= 1'b0;
        end else begin
            capture_ev_q <= cap_hit;
            if (cap_hit) begin
                capture_q <= count_q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_q <= 1'b0;
        end else if (run && cfg.mode == gpt_pkg::GPT_PWM) begin
            pwm_q <= (count_q >= cfg.match) ^ cfg.pwm_inv;
        end else begin
            pwm_q <= cfg.pwm_inv;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_periodic_reload;
        run && cfg.mode == gpt_pkg::GPT_PERIODIC && tick && zero
            |=> count_q == $past(cfg.load) && timeout_q;
    endproperty
    a_periodic_reload: assert property (p_periodic_reload)
        else $error("periodic half did not reload");

    property p_prescale_hold;
        run && cfg.mode == gpt_pkg::GPT_PERIODIC && pre_q != 8'h00 |=> $stable(count_q);
    endproperty
    a_prescale_hold: assert property (p_prescale_hold)
        else $error("count moved without a prescaler tick");

    property p_capture;
        run && cfg.mode == gpt_pkg::GPT_EDGE_TIME && edge_hit
            |=> capture_ev_q && capture_q == $past(count_q);
    endproperty
    a_capture: assert property (p_capture)
        else $error("edge not captured");

    property p_event_hold;
        run && cfg.mode == gpt_pkg::GPT_EVT_COUNT && !edge_hit |=> $stable(count_q);
    endproperty
    a_event_hold: assert property (p_event_hold)
        else $error("event count moved without an edge");

endmodule

// [verilog/gpt_block.sv]
// one general purpose timer block: two 16-bit halves or one 32-bit counter
// Behaviour
// - each timer block works on its own
// - two 16-bit halves, timer or event counter
// - halves join into one 32-bit counter
// - 32-bit runs rtc, one-shot or periodic
// - 16-bit one-shot/periodic with 8-bit prescaler
// - 16-bit half captures edges or makes pwm
// - count or time edges on input pins
// - timeouts can trigger an adc conversion
// - pwm drives pin, optional inversion
`timescale 1ns/100ps
module gpt_block (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire gpt_pkg::gpt_half_cfg_t cfg_lo,
    input wire gpt_pkg::gpt_half_cfg_t cfg_hi,
    input wire logic joined,
    input wire gpt_pkg::gpt_join_t join_mode,
    // interrupt control
    input wire logic [5:0] irq_mask,
    input wire logic [5:0] irq_clear,
    // timer pins
    input wire logic [1:0] tmr_pin_in,
    input wire logic rtc_in,
    output logic [1:0] tmr_pin_out,
    output logic [1:0] tmr_pin_oe_n,
    // status
    output gpt_pkg::gpt_half_stat_t stat_lo,
    output gpt_pkg::gpt_half_stat_t stat_hi,
    output logic [31:0] count32_q,
    output logic [5:0] status_q,
    output logic irq_q,
    output logic adc_trig_q
);

    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic rtc_s1_q;
    logic rtc_s2_q;
    logic rtc_prev_q;
    logic done32_q;
    gpt_pkg::gpt_half_cfg_t h_cfg [2];
    logic [15:0] h_cnt [2];
    logic [15:0] h_capv [2];
    logic [1:0] h_run;
    logic [1:0] h_to;
    logic [1:0] h_cap;
    logic [1:0] h_pwm;
    logic run32;
    logic rtc_edge;
    logic rtc_hit;
    logic to32;
    logic [31:0] load32;
    logic [31:0] match32;
    logic [5:0] ev;
    logic [5:0] status_d;

    // ****************************************
    // pin synchronisers
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
            rtc_s1_q <= 1'b0;
            rtc_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= tmr_pin_in;
            pin_s2_q <= pin_s1_q;
            rtc_s1_q <= rtc_in;
            rtc_s2_q <= rtc_s1_q;
        end
    end

    // edge history reads the second stage only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rtc_prev_q <= 1'b0;
        end else begin
            rtc_prev_q <= rtc_s2_q;
        end
    end

    // ****************************************
    // 16-bit halves
    // ****************************************
    assign h_cfg[0] = cfg_lo;
    assign h_cfg[1] = cfg_hi;

    for (genvar i = 0; i < 2; i++) begin : g_half
        assign h_run[i] = h_cfg[i].en && !joined;
        gpt_half u_half (
            .clk(clk),
            .rst(rst),
            .run(h_run[i]),
            .cfg(h_cfg[i]),
            .pin_lvl(pin_s2_q[i]),
            .count_q(h_cnt[i]),
            .capture_q(h_capv[i]),
            .timeout_q(h_to[i]),
            .capture_ev_q(h_cap[i]),
            .pwm_q(h_pwm[i])
        );
    end

    assign stat_lo = {h_cnt[0], h_capv[0]};
    assign stat_hi = {h_cnt[1], h_capv[1]};

    // ****************************************
    // pin drivers
    // ****************************************
    // pwm onto the pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmr_pin_out <= 2'h0;
            tmr_pin_oe_n <= gpt_pkg::GPT_PIN_OE_N_RST;
        end else begin
            for (int k = 0; k < 2; k++) begin
                tmr_pin_oe_n[k] <= !(h_run[k] && h_cfg[k].mode == gpt_pkg::GPT_PWM);
                tmr_pin_out[k] <= h_pwm[k];
            end
        end
    end

    // ****************************************
    // joined 32-bit counter
    // ****************************************
    assign load32 = {cfg_hi.load, cfg_lo.load};
    assign match32 = {cfg_hi.match, cfg_lo.match};
    assign run32 = joined && cfg_lo.en;
    assign rtc_edge = rtc_s2_q && !rtc_prev_q;
    assign rtc_hit = run32 && join_mode == gpt_pkg::GPT_J_RTC && rtc_edge
        && (count32_q + 32'h0000_0001) == match32;
    assign to32 = run32 && join_mode != gpt_pkg::GPT_J_RTC && count32_q == 32'h0
        && !done32_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count32_q <= gpt_pkg::GPT_CNT32_RST;
        end else if (!run32) begin
            count32_q <= load32;
        end else if (join_mode == gpt_pkg::GPT_J_RTC) begin
            if (rtc_edge) begin
                count32_q <= count32_q + 32'h0000_0001;
            end
        end else if (count32_q != 32'h0) begin
            count32_q <= count32_q - 32'h0000_0001;
        end else if (join_mode == gpt_pkg::GPT_J_PERIODIC) begin
            count32_q <= load32;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done32_q <= 1'b0;
        end else if (!run32) begin
            done32_q <= 1'b0;
        end else if (to32 && join_mode == gpt_pkg::GPT_J_ONE_SHOT) begin
            done32_q <= 1'b1;
        end
    end

    // ****************************************
    // events, interrupt and adc trigger
    // ****************************************
    // each half flags only its own events
    always_comb begin
        ev = 6'h00;
        ev[gpt_pkg::GPT_EV_TO_LO] = h_to[0];
        ev[gpt_pkg::GPT_EV_CAP_LO] = h_cap[0];
        ev[gpt_pkg::GPT_EV_TO_HI] = h_to[1];
        ev[gpt_pkg::GPT_EV_CAP_HI] = h_cap[1];
        ev[gpt_pkg::GPT_EV_TO_32] = to32;
        ev[gpt_pkg::GPT_EV_RTC] = rtc_hit;
    end

    assign status_d = (status_q & ~irq_clear) | ev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= gpt_pkg::GPT_STAT_RST;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_d & irq_mask);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adc_trig_q <= 1'b0;
        end else begin
            adc_trig_q <= (h_to[0] && cfg_lo.adc_en) || (h_to[1] && cfg_hi.adc_en)
                || ((to32 || rtc_hit) && cfg_lo.adc_en);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_own_flag;
        $rose(status_q[gpt_pkg::GPT_EV_TO_HI]) |-> $past(h_to[1]);
    endproperty
    a_own_flag: assert property (p_own_flag)
        else $error("high timeout flag rose without its event");

    property p_join_quiet;
        joined [*2] |-> h_to == 2'b00 && h_cap == 2'b00;
    endproperty
    a_join_quiet: assert property (p_join_quiet)
        else $error("half event while joined");

    property p_per32;
        run32 && join_mode == gpt_pkg::GPT_J_PERIODIC && count32_q == 32'h0
            |=> count32_q == $past(load32) && status_q[gpt_pkg::GPT_EV_TO_32];
    endproperty
    a_per32: assert property (p_per32)
        else $error("32-bit periodic reload or flag missed");

    property p_one32;
        run32 && join_mode == gpt_pkg::GPT_J_ONE_SHOT && count32_q == 32'h0
            |=> count32_q == 32'h0 && !to32;
    endproperty
    a_one32: assert property (p_one32)
        else $error("32-bit one-shot did not stop");

    property p_rtc_step;
        run32 && join_mode == gpt_pkg::GPT_J_RTC && rtc_edge
            |=> count32_q == $past(count32_q) + 32'h0000_0001;
    endproperty
    a_rtc_step: assert property (p_rtc_step)
        else $error("rtc did not step on its tick");

    property p_adc;
        h_to[0] && cfg_lo.adc_en |=> adc_trig_q;
    endproperty
    a_adc: assert property (p_adc)
        else $error("adc trigger missing after timeout");

    property p_pwm_pin;
        h_run[0] && cfg_lo.mode == gpt_pkg::GPT_PWM
            |=> !tmr_pin_oe_n[0] && tmr_pin_out[0] == $past(h_pwm[0]);
    endproperty
    a_pwm_pin: assert property (p_pwm_pin)
        else $error("pwm not on pin");

    property p_set_wins;
        ev[gpt_pkg::GPT_EV_TO_LO] && irq_clear[gpt_pkg::GPT_EV_TO_LO]
            |=> status_q[gpt_pkg::GPT_EV_TO_LO];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost against clear");

    property p_irq;
        (ev & irq_mask) != 6'h00 |=> irq_q
            ##1 (irq_q || $past(irq_clear != 6'h00 || (status_q & irq_mask) == 6'h00));
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked event raised no request");

    cover property (!tmr_pin_oe_n[0] && $rose(tmr_pin_out[0]));
    cover property (rtc_hit);
    cover property (h_cap[1]);
    cover property (to32 && join_mode == gpt_pkg::GPT_J_PERIODIC);

endmodule

// [verification/gpt_pin_model.sv]
// pin side model: event sources on the timer and rtc inputs, load on the pins
`timescale 1ns/100ps
module gpt_pin_model (
    // clock
    input wire logic clk,
    // block pins
    input wire logic [1:0] tmr_pin_out,
    input wire logic [1:0] tmr_pin_oe_n,
    // wire levels back to the block
    output logic [1:0] pin_lvl,
    output logic rtc_lvl
);
    logic [2:0] ext_q = 3'h0;

    // ****************************************
    // wire levels
    // ****************************************
    // block drives pin
    always_comb begin
        pin_lvl[0] = tmr_pin_oe_n[0] ? ext_q[0] : tmr_pin_out[0];
        pin_lvl[1] = tmr_pin_oe_n[1] ? ext_q[1] : tmr_pin_out[1];
        rtc_lvl = ext_q[2];
    end

    // ****************************************
    // event pulses
    // ****************************************
    // external edge source
    // hold sets the pace, so callers can be prompt or slow
    task automatic pulse(input int idx, input int n, input int hold);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            ext_q[idx] <= 1'b1;
            repeat (hold) @(posedge clk);
            ext_q[idx] <= 1'b0;
            repeat (hold) @(posedge clk);
        end
    endtask
endmodule

// [verification/gpt_block_tb.sv]
// self-checking bench of one timer block
`timescale 1ns/100ps
module gpt_block_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    gpt_pkg::gpt_half_cfg_t cfg_lo = '0;
    gpt_pkg::gpt_half_cfg_t cfg_hi = '0;
    logic joined = 1'b0;
    gpt_pkg::gpt_join_t join_mode = gpt_pkg::GPT_J_ONE_SHOT;
    logic [5:0] irq_mask = 6'h00;
    logic [5:0] irq_clear = 6'h00;
    logic [1:0] pin_lvl;
    logic rtc_lvl;
    logic [1:0] tmr_pin_out;
    logic [1:0] tmr_pin_oe_n;
    gpt_pkg::gpt_half_stat_t stat_lo;
    gpt_pkg::gpt_half_stat_t stat_hi;
    logic [31:0] count32_q;
    logic [5:0] status_q;
    logic irq_q;
    logic adc_trig_q;
    int n_errors = 0;
    int compares = 0;
    int n_adc = 0;
    int a0 = 0;
    int hcnt = 0;
    int exp_c = 0;

    always #5 clk = ~clk;

    gpt_block uut (.clk(clk), .rst(rst), .cfg_lo(cfg_lo), .cfg_hi(cfg_hi), .joined(joined),
        .join_mode(join_mode), .irq_mask(irq_mask), .irq_clear(irq_clear),
        .tmr_pin_in(pin_lvl), .rtc_in(rtc_lvl), .tmr_pin_out(tmr_pin_out),
        .tmr_pin_oe_n(tmr_pin_oe_n), .stat_lo(stat_lo), .stat_hi(stat_hi),
        .count32_q(count32_q), .status_q(status_q), .irq_q(irq_q), .adc_trig_q(adc_trig_q));

    gpt_pin_model pins (.clk(clk), .tmr_pin_out(tmr_pin_out), .tmr_pin_oe_n(tmr_pin_oe_n),
        .pin_lvl(pin_lvl), .rtc_lvl(rtc_lvl));

    always @(posedge clk) begin
        if (adc_trig_q === 1'b1) begin
            n_adc <= n_adc + 1;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic gpt_pkg::gpt_half_cfg_t mk(input logic en, input gpt_pkg::gpt_mode_t md,
            input gpt_pkg::gpt_edge_t ed, input logic inv, input logic [7:0] pre,
            input logic [15:0] ld, input logic [15:0] mt);
        mk = '{en, md, ed, inv, 1'b1, pre, ld, mt};
    endfunction

    // enables low for one edge first, so the counters start from the new load value
    task automatic set(input gpt_pkg::gpt_half_cfg_t lo, input gpt_pkg::gpt_half_cfg_t hi,
            input logic j, input gpt_pkg::gpt_join_t jm);
        gpt_pkg::gpt_half_cfg_t lo_off;
        gpt_pkg::gpt_half_cfg_t hi_off;
        lo_off = lo;
        lo_off.en = 1'b0;
        hi_off = hi;
        hi_off.en = 1'b0;
        @(posedge clk);
        cfg_lo <= lo_off;
        cfg_hi <= hi_off;
        joined <= j;
        join_mode <= jm;
        @(posedge clk);
        cfg_lo <= lo;
        cfg_hi <= hi;
        #1;
    endtask

    // stop everything, then wipe the sticky status
    task automatic idle();
        set('0, '0, 1'b0, gpt_pkg::GPT_J_ONE_SHOT);
        @(posedge clk);
        irq_clear <= 6'h3f;
        @(posedge clk);
        irq_clear <= 6'h00;
        tick(2);
    endtask

    task automatic wait_stat(input int b, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            if (status_q[b] === 1'b1) break;
            tick(1);
        end
        check(i < lim, "status bit never set");
    endtask

    // cycles between two adc trigger pulses
    task automatic adc_gap(input int exp);
        int t0;
        int i;
        t0 = -1;
        for (i = 0; i < 600; i++) begin
            tick(1);
            if (adc_trig_q === 1'b1) begin
                if (t0 >= 0) break;
                t0 = i;
            end
        end
        check(t0 >= 0 && i - t0 == exp, "adc trigger spacing");
    endtask

    task automatic give_verdict();
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        tick(1);
        check(tmr_pin_oe_n === 2'h3 && tmr_pin_out === 2'h0 && status_q === 6'h00
            && count32_q === 32'hffff_ffff && stat_lo.count === 16'hffff
            && irq_q === 1'b0 && adc_trig_q === 1'b0, "reset values");
        @(posedge clk);
        rst <= 1'b0;
        irq_mask <= 6'h3f;
        tick(2);
        for (int p = 0; p < 3; p++) begin
            set(mk(1'b1, gpt_pkg::GPT_PERIODIC, gpt_pkg::GPT_EDGE_RISE, 1'b0, 8'((1 << p) - 1),
                16'h0002, 16'h0000), '0, 1'b0, gpt_pkg::GPT_J_ONE_SHOT);
            wait_stat(0, 40);
            check(irq_q === 1'b1, "irq not raised");
            adc_gap(3 * (1 << p));
            idle();
        end
        set(mk(1'b1, gpt_pkg::GPT_PERIODIC, gpt_pkg::GPT_EDGE_RISE, 1'b0, 8'h00, 16'h0002,
            16'h0000), '0, 1'b0, gpt_pkg::GPT_J_ONE_SHOT);
        tick(10);
        @(posedge clk);
        irq_mask <= 6'h00;
        tick(2);
        check(status_q[0] === 1'b1 && irq_q === 1'b0, "masked irq");
        idle();
        check(status_q === 6'h00 && irq_q === 1'b0, "clear failed");
        @(posedge clk);
        irq_mask <= 6'h3f;
        a0 = n_adc;
        set('0, mk(1'b1, gpt_pkg::GPT_ONE_SHOT, gpt_pkg::GPT_EDGE_RISE, 1'b0, 8'h01, 16'h0003,
            16'h0000), 1'b0, gpt_pkg::GPT_J_ONE_SHOT);
        wait_stat(2, 40);
        tick(20);
        check(stat_hi.count === 16'h0000 && n_adc - a0 == 1, "one-shot");
        idle();
        for (int k = 0; k < 3; k++) begin
            set(mk(1'b1, gpt_pkg::GPT_EVT_COUNT, gpt_pkg::gpt_edge_t'(k), 1'b0, 8'h00, 16'h000a,
                16'h0000), '0, 1'b0, gpt_pkg::GPT_J_ONE_SHOT);
            pins.pulse(0, 3, k + 1);
            tick(6);
            exp_c = (k == 2) ? 4 : 7;
            check(stat_lo.count === 16'(exp_c), "event count");
            idle();
        end
        set('0, mk(1'b1, gpt_pkg::GPT_EDGE_TIME, gpt_pkg::GPT_EDGE_RISE, 1'b0, 8'hff, 16'h00ff,
            16'h0000), 1'b0, gpt_pkg::GPT_J_ONE_SHOT);
        tick(4);
        pins.pulse(1, 1, 2);
        wait_stat(3, 20);
        check(stat_hi.capture === 16'h00ff, "capture value");
        idle();
        for (int v = 0; v < 2; v++) begin
            set(mk(1'b1, gpt_pkg::GPT_PWM, gpt_pkg::GPT_EDGE_RISE, v[0], 8'h00, 16'h0009,
                16'h0004), '0, 1'b0, gpt_pkg::GPT_J_ONE_SHOT);
            tick(4);
            hcnt = 0;
            repeat (20) begin
                tick(1);
                if (pin_lvl[0] === 1'b1) hcnt++;
            end
            check(tmr_pin_oe_n[0] === 1'b0 && hcnt == (v ? 8 : 12), "pwm duty");
            idle();
        end
        check(tmr_pin_oe_n === 2'h3, "pin still driven");
        set(mk(1'b0, gpt_pkg::GPT_ONE_SHOT, gpt_pkg::GPT_EDGE_RISE, 1'b0, 8'h00, 16'h5678,
            16'h0000), mk(1'b0, gpt_pkg::GPT_ONE_SHOT, gpt_pkg::GPT_EDGE_RISE, 1'b0, 8'h00,
            16'h1234, 16'h0000), 1'b1, gpt_pkg::GPT_J_PERIODIC);
        tick(2);
        check(count32_q === 32'h1234_5678, "joined load");
        set(mk(1'b1, gpt_pkg::GPT_ONE_SHOT, gpt_pkg::GPT_EDGE_RISE, 1'b0, 8'h00, 16'h0003,
            16'h0000), '0, 1'b1, gpt_pkg::GPT_J_PERIODIC);
        wait_stat(4, 20);
        adc_gap(4);
        idle();
        a0 = n_adc;
        set(mk(1'b1, gpt_pkg::GPT_ONE_SHOT, gpt_pkg::GPT_EDGE_RISE, 1'b0, 8'h00, 16'h0005,
            16'h0000), '0, 1'b1, gpt_pkg::GPT_J_ONE_SHOT);
        wait_stat(4, 20);
        tick(10);
        check(count32_q === 32'h0000_0000 && n_adc - a0 == 1, "joined one-shot");
        idle();
        set(mk(1'b0, gpt_pkg::GPT_ONE_SHOT, gpt_pkg::GPT_EDGE_RISE, 1'b0, 8'h00, 16'h0000,
            16'h0003), '0, 1'b1, gpt_pkg::GPT_J_RTC);
        tick(2);
        set(mk(1'b1, gpt_pkg::GPT_ONE_SHOT, gpt_pkg::GPT_EDGE_RISE, 1'b0, 8'h00, 16'h0000,
            16'h0003), '0, 1'b1, gpt_pkg::GPT_J_RTC);
        pins.pulse(2, 3, 2);
        tick(6);
        check(count32_q === 32'h0000_0003 && status_q[5] === 1'b1, "rtc match");
        idle();
        give_verdict();
    end
endmodule
